/* File: rtl/udt_dma_trigger.sv */
// udt_dma_trigger: event flags, dma triggers, debug freeze and apb registers
// assumes the fifo core runs on core_clk and reports levels and strobes
//
// Overview of operation
// - receive dma request output asks dma to move one received item.
// - separate transmit dma request driven only by the transmit level event.
// - receive request sourced only from receive timeout and receive level.
// - timeout sets when fifo holds data and line idle for selected time.
// - timeout clears on fifo empty, index read or clear write.
// - fifo on: receive level sets when fill reaches trigger level.
// - fifo on: receive level clears below level, index read or clear.
// - fifo off: receive level sets on fill, clears on data read.
// - fifo on: transmit level sets on crossing down through level.
// - fifo on: transmit level clears above level, index read or clear.
// - fifo off: transmit level sets when fill drops to empty, clears on data write.
// - halted with free bit set: module keeps running.
// - halted, free and soft clear: module freezes at once.
// - halted, free clear, soft set: finish transfer then freeze.
// - key-guarded fields change only when the write carries the key.
// - power enable changes only with key byte 26h.
`timescale 1ns/1ps
module udt_dma_trigger import udt_pkg::*; #(
  parameter int FIFO_DEPTH = 16,
  parameter int LEVEL_W = 5
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [LEVEL_W-1:0] rxFillLevel,
  input wire logic [LEVEL_W-1:0] txFillLevel,
  input wire logic rxCharArrived,
  input wire logic [7:0] rxDataIn,
  input wire logic transferBusy,
  input wire logic cpuHalted,
  output logic rxPopPulse,
  output logic txPushPulse,
  output logic [7:0] txDataOut,
  output logic moduleRunEnable,
  output logic receive_dma_request,
  output logic transmit_dma_request
);

  ////////////////////////////////////////////////////////////////////////
  // functions

  function automatic logic [31:0] mergeBytes(input logic [31:0] oldVal,
                                             input logic [31:0] newVal,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = oldVal;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = newVal[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // trigger threshold: quarter steps of the fifo depth
  function automatic logic [LEVEL_W-1:0] levelOf(input logic [2:0] sel);
    int unsigned steps;
    steps = (sel > 3'h3) ? 4 : int'(sel) + 1;
    return LEVEL_W'((FIFO_DEPTH / 4) * steps);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // registers

  logic powerEnable_reg;
  logic [1:0] debugCtrl_reg;
  logic [31:0] eventMask_reg;
  logic [31:0] serialCtrl_reg;
  logic [31:0] levelSelect_reg;
  logic rxTimeout_reg;
  logic rxLevel_reg;
  logic txLevel_reg;
  logic frozen_reg;
  logic [LEVEL_W-1:0] rxFillPrev_reg;
  logic [LEVEL_W-1:0] txFillPrev_reg;
  logic [15:0] idleCount_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic [31:0] prdata_reg;
  logic rxPop_reg;
  logic txPush_reg;
  logic [7:0] transmit_data_reg;
  logic runEnable_reg;
  logic rxReq_reg;
  logic txReq_reg;

  ////////////////////////////////////////////////////////////////////////
  // apb decode

  wire setupPhase = psel & ~penable & ~pready_reg;
  wire accessDone = psel & penable & pready_reg;
  wire writeDone = accessDone & pwrite;
  wire readDone = accessDone & ~pwrite;
  wire hitPower = (paddr == OFS_POWER_ENABLE);
  wire hitDebug = (paddr == OFS_DEBUG_BEHAVIOUR_CONTROL);
  wire hitIndex = (paddr == OFS_PENDING_EVENT_INDEX);
  wire hitMask = (paddr == OFS_EVENT_MASK);
  wire hitRaw = (paddr == OFS_RAW_EVENT_STATUS);
  wire hitMasked = (paddr == OFS_MASKED_EVENT_STATUS);
  wire hitSet = (paddr == OFS_EVENT_SET);
  wire hitClear = (paddr == OFS_EVENT_CLEAR);
  wire hitCtl = (paddr == OFS_SERIAL_CONTROL_ZERO);
  wire hitLevelSel = (paddr == OFS_FIFO_LEVEL_SELECT);
  wire hitTxData = (paddr == OFS_TRANSMIT_DATA);
  wire hitRxData = (paddr == OFS_RECEIVE_DATA);
  wire hitOther = (paddr == OFS_RESET_CONTROL) |
    (paddr == OFS_CLOCK_CONFIG) | (paddr == OFS_PERIPHERAL_STATUS) |
    (paddr == OFS_CLOCK_DIVIDER) | (paddr == OFS_EVENT_MODE) |
    (paddr == OFS_EVENT_CONTROL) | (paddr == OFS_LINE_FORMAT_CONTROL) |
    (paddr == OFS_SERIAL_STATUS) | (paddr == OFS_BAUD_INTEGER_DIVISOR) |
    (paddr == OFS_BAUD_FRACTION_DIVISOR) |
    (paddr == OFS_GLITCH_FILTER_CONTROL) |
    (paddr == OFS_OWN_ADDRESS_MASK) | (paddr == OFS_OWN_ADDRESS);
  wire hitAny = hitPower | hitDebug | hitIndex | hitMask | hitRaw |
    hitMasked | hitSet | hitClear | hitCtl | hitLevelSel | hitTxData |
    hitRxData | hitOther;
  wire keyLaneOk = pstrb[3] & (pwdata[KEY_LSB +: 8] == POWER_KEY);

  ////////////////////////////////////////////////////////////////////////
  // event status and index

  wire [31:0] rawEvents = (32'(rxTimeout_reg) << EVT_RX_TIMEOUT_BIT) |
    (32'(rxLevel_reg) << EVT_RX_LEVEL_BIT) |
    (32'(txLevel_reg) << EVT_TX_LEVEL_BIT);
  wire [31:0] maskedEvents = rawEvents & eventMask_reg;
  wire [7:0] pendingIndex =
    maskedEvents[EVT_RX_TIMEOUT_BIT] ? IDX_RX_TIMEOUT :
    maskedEvents[EVT_RX_LEVEL_BIT] ? IDX_RX_LEVEL :
    maskedEvents[EVT_TX_LEVEL_BIT] ? IDX_TX_LEVEL : IDX_NONE;
  wire indexRead = readDone & hitIndex;
  wire [31:0] clearWord = (writeDone & hitClear) ?
    (pwdata & EVENT_BITS) : RST_ZERO;
  wire [31:0] setWord = (writeDone & hitSet) ?
    (pwdata & EVENT_BITS) : RST_ZERO;
  wire clrTimeout = clearWord[EVT_RX_TIMEOUT_BIT] |
    (indexRead & pendingIndex == IDX_RX_TIMEOUT);
  wire clrRxLevel = clearWord[EVT_RX_LEVEL_BIT] |
    (indexRead & pendingIndex == IDX_RX_LEVEL);
  wire clrTxLevel = clearWord[EVT_TX_LEVEL_BIT] |
    (indexRead & pendingIndex == IDX_TX_LEVEL);

  ////////////////////////////////////////////////////////////////////////
  // event conditions

  wire fifoOn = serialCtrl_reg[CTL_FIFO_ENABLE_BIT];
  wire active = powerEnable_reg & ~frozen_reg;
  wire [LEVEL_W-1:0] rxThr = levelOf(levelSelect_reg[RX_LEVEL_LSB +: 3]);
  wire [LEVEL_W-1:0] txThr = levelOf(levelSelect_reg[TX_LEVEL_LSB +: 3]);
  wire [3:0] idleSel = levelSelect_reg[IDLE_TIMEOUT_LSB +: 4];
  wire [15:0] idleLimit = 16'(int'(idleSel) * IDLE_UNIT_CYCLES);
  wire rxDataRead = readDone & hitRxData;
  wire txDataWrite = writeDone & hitTxData;
  wire rxEmpty = (rxFillLevel == '0);
  wire idleHit = (idleSel != 4'h0) & ~rxEmpty & ~rxCharArrived &
    (idleCount_reg == idleLimit - 16'h0001);
  wire rxReach = (rxFillLevel >= rxThr) & (rxFillPrev_reg < rxThr);
  wire rxBelow = (rxFillLevel < rxThr);
  wire txCross = (txFillLevel <= txThr) & (txFillPrev_reg > txThr);
  wire txAbove = (txFillLevel > txThr);
  wire txEmptyEdge = (txFillLevel == '0) & (txFillPrev_reg != '0);
  wire setTimeout = (active & idleHit) | setWord[EVT_RX_TIMEOUT_BIT];
  wire setRxLevel = setWord[EVT_RX_LEVEL_BIT] | (active & (fifoOn ?
    rxReach : rxCharArrived));
  wire setTxLevel = setWord[EVT_TX_LEVEL_BIT] | (active & (fifoOn ?
    txCross : txEmptyEdge));
  wire dropTimeout = clrTimeout | rxEmpty;
  wire dropRxLevel = clrRxLevel | (fifoOn ? rxBelow : rxDataRead);
  wire dropTxLevel = clrTxLevel | (fifoOn ? txAbove : txDataWrite);

  // set wins over clear
  wire rxTimeout_next = setTimeout | (rxTimeout_reg & ~dropTimeout);
  wire rxLevel_next = setRxLevel | (rxLevel_reg & ~dropRxLevel);
  wire txLevel_next = setTxLevel | (txLevel_reg & ~dropTxLevel);

  ////////////////////////////////////////////////////////////////////////
  // debug freeze

  wire freeRun = debugCtrl_reg[DBG_FREE_BIT];
  wire softStop = debugCtrl_reg[DBG_SOFT_BIT];
  wire frozen_next = cpuHalted & ~freeRun &
    (~softStop | ~transferBusy | frozen_reg);

  ////////////////////////////////////////////////////////////////////////
  // read mux

  wire [31:0] readWord =
    hitPower ? 32'(powerEnable_reg) :
    hitDebug ? 32'(debugCtrl_reg) :
    hitIndex ? 32'(pendingIndex) :
    hitMask ? eventMask_reg :
    hitRaw ? rawEvents :
    hitMasked ? maskedEvents :
    hitCtl ? serialCtrl_reg :
    hitLevelSel ? levelSelect_reg :
    hitTxData ? 32'(transmit_data_reg) :
    hitRxData ? 32'(rxDataIn) : RST_ZERO;

  ////////////////////////////////////////////////////////////////////////
  // apb response

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= RST_ZERO;
    end else begin
      pready_reg <= setupPhase;
      pslverr_reg <= setupPhase & ~hitAny;
      if (setupPhase) begin
        prdata_reg <= pwrite ? RST_ZERO : readWord;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // software registers

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      powerEnable_reg <= 1'b0;
      debugCtrl_reg <= 2'h0;
      eventMask_reg <= RST_ZERO;
      serialCtrl_reg <= RST_ZERO;
      levelSelect_reg <= RST_ZERO;
    end else if (writeDone) begin
      if (hitPower & keyLaneOk & pstrb[0]) begin
        powerEnable_reg <= pwdata[POWER_ENABLE_BIT];
      end
      if (hitDebug & pstrb[0]) begin
        debugCtrl_reg <= pwdata[1:0];
      end
      if (hitMask) begin
        eventMask_reg <= mergeBytes(eventMask_reg, pwdata, pstrb) &
          EVENT_BITS;
      end
      if (hitCtl) begin
        serialCtrl_reg <= mergeBytes(serialCtrl_reg, pwdata, pstrb);
      end
      if (hitLevelSel) begin
        levelSelect_reg <= mergeBytes(levelSelect_reg, pwdata, pstrb);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // event flags and idle counter

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rxTimeout_reg <= 1'b0;
      rxLevel_reg <= 1'b0;
      txLevel_reg <= 1'b0;
      rxFillPrev_reg <= '0;
      txFillPrev_reg <= '0;
      idleCount_reg <= 16'h0000;
      frozen_reg <= 1'b0;
    end else begin
      rxTimeout_reg <= rxTimeout_next;
      rxLevel_reg <= rxLevel_next;
      txLevel_reg <= txLevel_next;
      rxFillPrev_reg <= rxFillLevel;
      txFillPrev_reg <= txFillLevel;
      frozen_reg <= frozen_next;
      if (rxCharArrived | rxEmpty | idleHit) begin
        idleCount_reg <= 16'h0000;
      end else if (active & idleCount_reg != 16'hffff) begin
        idleCount_reg <= idleCount_reg + 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // core strobes and dma requests

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rxPop_reg <= 1'b0;
      txPush_reg <= 1'b0;
      transmit_data_reg <= 8'h00;
      runEnable_reg <= 1'b0;
      rxReq_reg <= 1'b0;
      txReq_reg <= 1'b0;
    end else begin
      rxPop_reg <= rxDataRead;
      txPush_reg <= txDataWrite;
      if (txDataWrite & pstrb[0]) begin
        transmit_data_reg <= pwdata[7:0];
      end
      runEnable_reg <= powerEnable_reg & ~frozen_next;
      rxReq_reg <= rxTimeout_next | rxLevel_next;
      txReq_reg <= txLevel_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign rxPopPulse = rxPop_reg;
  assign txPushPulse = txPush_reg;
  assign txDataOut = transmit_data_reg;
  assign moduleRunEnable = runEnable_reg;
  assign receive_dma_request = rxReq_reg;
  assign transmit_dma_request = txReq_reg;

endmodule // udt_dma_trigger

/* File: rtl/udt_pkg.sv */
// udt_pkg: shared constants of the uart event and dma trigger block
// assumes a 32-bit apb bus and byte addresses within the module window
package udt_pkg;
  localparam int ADDR_W = 13;
  // register byte offsets
  localparam logic [12:0] OFS_POWER_ENABLE = 13'h0800;
  localparam logic [12:0] OFS_RESET_CONTROL = 13'h0804;
  localparam logic [12:0] OFS_CLOCK_CONFIG = 13'h0808;
  localparam logic [12:0] OFS_PERIPHERAL_STATUS = 13'h0814;
  localparam logic [12:0] OFS_CLOCK_DIVIDER = 13'h1000;
  localparam logic [12:0] OFS_DEBUG_BEHAVIOUR_CONTROL = 13'h1018;
  localparam logic [12:0] OFS_PENDING_EVENT_INDEX = 13'h1020;
  localparam logic [12:0] OFS_EVENT_MASK = 13'h1028;
  localparam logic [12:0] OFS_RAW_EVENT_STATUS = 13'h1030;
  localparam logic [12:0] OFS_MASKED_EVENT_STATUS = 13'h1038;
  localparam logic [12:0] OFS_EVENT_SET = 13'h1040;
  localparam logic [12:0] OFS_EVENT_CLEAR = 13'h1048;
  localparam logic [12:0] OFS_EVENT_MODE = 13'h10e0;
  localparam logic [12:0] OFS_EVENT_CONTROL = 13'h10e4;
  localparam logic [12:0] OFS_SERIAL_CONTROL_ZERO = 13'h1100;
  localparam logic [12:0] OFS_LINE_FORMAT_CONTROL = 13'h1104;
  localparam logic [12:0] OFS_SERIAL_STATUS = 13'h1108;
  localparam logic [12:0] OFS_FIFO_LEVEL_SELECT = 13'h110c;
  localparam logic [12:0] OFS_BAUD_INTEGER_DIVISOR = 13'h1110;
  localparam logic [12:0] OFS_BAUD_FRACTION_DIVISOR = 13'h1114;
  localparam logic [12:0] OFS_GLITCH_FILTER_CONTROL = 13'h1118;
  localparam logic [12:0] OFS_TRANSMIT_DATA = 13'h1120;
  localparam logic [12:0] OFS_RECEIVE_DATA = 13'h1124;
  localparam logic [12:0] OFS_OWN_ADDRESS_MASK = 13'h1148;
  localparam logic [12:0] OFS_OWN_ADDRESS = 13'h114c;
  // key field
  localparam int KEY_LSB = 24;
  localparam logic [7:0] POWER_KEY = 8'h26;
  localparam int POWER_ENABLE_BIT = 0;
  // debug behaviour fields
  localparam int DBG_FREE_BIT = 0;
  localparam int DBG_SOFT_BIT = 1;
  // serial control zero fields
  localparam int CTL_FIFO_ENABLE_BIT = 1;
  // fifo level select fields
  localparam int TX_LEVEL_LSB = 0;
  localparam int RX_LEVEL_LSB = 4;
  localparam int IDLE_TIMEOUT_LSB = 8;
  // event bit positions (index minus one)
  localparam int EVT_RX_TIMEOUT_BIT = 0;
  localparam int EVT_RX_LEVEL_BIT = 10;
  localparam int EVT_TX_LEVEL_BIT = 11;
  localparam logic [7:0] IDX_RX_TIMEOUT = 8'h01;
  localparam logic [7:0] IDX_RX_LEVEL = 8'h0b;
  localparam logic [7:0] IDX_TX_LEVEL = 8'h0c;
  localparam logic [7:0] IDX_NONE = 8'h00;
  localparam logic [31:0] EVENT_BITS = 32'h0000_0c01;
  // reset values
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  // cycles per idle-timeout unit (stand-in for one bit time)
  localparam int IDLE_UNIT_CYCLES = 16;
endpackage

/* File: bench/udt_dma_trigger_props.sv */
// udt_dma_trigger_props: port-level checker for the trigger block
// assumes apb on core_clk, one clock domain, bound to the top module
`timescale 1ns/1ps
module udt_dma_trigger_props import udt_pkg::*; #(
  parameter int LEVEL_W = 5
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic [LEVEL_W-1:0] txFillLevel,
  input wire logic transferBusy,
  input wire logic cpuHalted,
  input wire logic rxPopPulse,
  input wire logic txPushPulse,
  input wire logic [7:0] txDataOut,
  input wire logic moduleRunEnable,
  input wire logic receive_dma_request,
  input wire logic transmit_dma_request
);
  ////////////////////////////////////////////////////////////////////////////
  logic pwrOn, dbgFree, dbgSoft;
  wire apbDone = psel && penable && pready;
  wire apbWr = apbDone && pwrite;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pwrOn <= 1'b0;
      dbgFree <= 1'b0;
      dbgSoft <= 1'b0;
    end else if (apbWr && paddr == OFS_POWER_ENABLE) begin
      if (pwdata[31:24] == POWER_KEY) pwrOn <= pwdata[0];
    end else if (apbWr && paddr == OFS_DEBUG_BEHAVIOUR_CONTROL) begin
      dbgFree <= pwdata[DBG_FREE_BIT];
      dbgSoft <= pwdata[DBG_SOFT_BIT];
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence s_setup; psel && !penable; endsequence
  sequence s_wr(logic [ADDR_W-1:0] a); apbWr && paddr == a; endsequence
  property p_ready; s_setup |=> pready; endproperty
  property p_pop;
    apbDone && !pwrite && paddr == OFS_RECEIVE_DATA |=> rxPopPulse;
  endproperty
  property p_push;
    logic [7:0] d;
    (s_wr(OFS_TRANSMIT_DATA), d = pwdata[7:0]) |=>
      txPushPulse && txDataOut == d;
  endproperty
  property p_key; (!pwrOn)[*2] |-> !moduleRunEnable; endproperty
  property p_free; (pwrOn && dbgFree)[*2] |-> moduleRunEnable; endproperty
  property p_stop;
    (cpuHalted && !dbgFree && !dbgSoft)[*2] |-> !moduleRunEnable;
  endproperty
  property p_soft;
    $rose(cpuHalted) && !dbgFree && dbgSoft && transferBusy && moduleRunEnable
      |=> moduleRunEnable;
  endproperty
  property p_txset;
    s_wr(OFS_EVENT_SET) ##0 pwdata[EVT_TX_LEVEL_BIT] |=> transmit_dma_request;
  endproperty
  property p_rxset;
    s_wr(OFS_EVENT_SET) ##0 pwdata[EVT_RX_LEVEL_BIT] |=> receive_dma_request;
  endproperty
  property p_txclr;
    s_wr(OFS_EVENT_CLEAR) ##0
      (pwdata[EVT_TX_LEVEL_BIT] && $stable(txFillLevel))
      |=> !transmit_dma_request;
  endproperty
  a_ready: assert property (p_ready) else $error("no ready");
  a_pop: assert property (p_pop) else $error("no pop after data read");
  a_push: assert property (p_push) else $error("bad push after write");
  a_key: assert property (p_key) else $error("run without power");
  a_free: assert property (p_free) else $error("free run stopped");
  a_stop: assert property (p_stop) else $error("no immediate stop");
  a_soft: assert property (p_soft) else $error("stopped mid transfer");
  a_txset: assert property (p_txset) else $error("tx request missing");
  a_rxset: assert property (p_rxset) else $error("rx request missing");
  a_txclr: assert property (p_txclr) else $error("tx request stuck");
endmodule // udt_dma_trigger_props
bind udt_dma_trigger udt_dma_trigger_props #(.LEVEL_W(LEVEL_W)) props_i (
  .core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .txFillLevel(txFillLevel), .transferBusy(transferBusy),
  .cpuHalted(cpuHalted), .rxPopPulse(rxPopPulse), .txPushPulse(txPushPulse),
  .txDataOut(txDataOut), .moduleRunEnable(moduleRunEnable),
  .receive_dma_request(receive_dma_request),
  .transmit_dma_request(transmit_dma_request));

/* File: bench/udt_fifo_model.sv */
// udt_fifo_model: behavioural fifo core beside the trigger block
// assumes bench commands arrive as one-cycle levels on core_clk
`timescale 1ns/1ps
module udt_fifo_model (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic rxPushReq,
  input wire logic [7:0] rxByte,
  input wire logic txDrainReq,
  input wire logic rxPopPulse,
  input wire logic txPushPulse,
  output logic [4:0] rxFill,
  output logic [4:0] txFill,
  output logic rxCharArrived,
  output logic [7:0] rxDataIn
);
  logic [7:0] q[$];
  logic [7:0] lastByte;
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      q.delete();
      lastByte = 8'h00;
      txFill <= 5'h00;
      rxCharArrived <= 1'b0;
    end else begin
      rxCharArrived <= rxPushReq;
      if (rxPushReq) q.push_back(rxByte);
      if (rxPopPulse && q.size() > 0) lastByte = q.pop_front();
      if (txPushPulse) txFill <= txFill + 5'h01;
      else if (txDrainReq && txFill != 5'h00) txFill <= txFill - 5'h01;
    end
    rxFill <= 5'(q.size());
    // empty head shows the inverted last popped byte, not the old byte
    rxDataIn <= (q.size() > 0) ? q[0] : ~lastByte;
  end
endmodule // udt_fifo_model

/* File: bench/udt_dma_trigger_tb_top.sv */
// udt_dma_trigger_tb_top: self-checking bench for the trigger block
// assumes udt_fifo_model as fifo core and the bench as dma and software
`timescale 1ns/1ps
module udt_dma_trigger_tb_top import udt_pkg::*; ;
  logic core_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, cpuHalted = 1'b0, transferBusy = 1'b0;
  logic rxPushReq = 1'b0, txDrainReq = 1'b0, pready, pslverr, er;
  logic [12:0] paddr = 13'h0000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [7:0] rxByte = 8'h00, rxDataIn, txDataOut;
  logic [4:0] rxFill, txFill;
  logic rxCharArrived, rxPopPulse, txPushPulse, moduleRunEnable;
  logic receive_dma_request, transmit_dma_request;
  int err_count = 0, num_checks = 0, cyc = 0;
  logic [7:0] expQ[$];
  always #2.5 core_clk = ~core_clk;
  udt_dma_trigger #(.FIFO_DEPTH(16), .LEVEL_W(5)) dut (.core_clk(core_clk),
    .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rxFillLevel(rxFill),
    .txFillLevel(txFill), .rxCharArrived(rxCharArrived), .rxDataIn(rxDataIn),
    .transferBusy(transferBusy), .cpuHalted(cpuHalted),
    .rxPopPulse(rxPopPulse), .txPushPulse(txPushPulse), .txDataOut(txDataOut),
    .moduleRunEnable(moduleRunEnable),
    .receive_dma_request(receive_dma_request),
    .transmit_dma_request(transmit_dma_request));
  udt_fifo_model fifo (.core_clk(core_clk), .rst_n(rst_n),
    .rxPushReq(rxPushReq), .rxByte(rxByte), .txDrainReq(txDrainReq),
    .rxPopPulse(rxPopPulse), .txPushPulse(txPushPulse), .rxFill(rxFill),
    .txFill(txFill), .rxCharArrived(rxCharArrived), .rxDataIn(rxDataIn));
  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out;
    if (err_count == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      err_count++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic step(int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic apb(logic w, logic [12:0] a, logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic push_rx(int n);
    logic [7:0] b;
    repeat (n) begin
      b = 8'($urandom);
      expQ.push_back(b);
      rxByte <= b;
      rxPushReq <= 1'b1;
      @(posedge core_clk);
    end
    rxPushReq <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd_rx;
    apb(1'b0, OFS_RECEIVE_DATA, 32'h0);
    chk("receive_data", {24'h0, rd[7:0]}, {24'h0, expQ.pop_front()});
  endtask
  task automatic wr_tx(int n);
    logic [31:0] d;
    repeat (n) begin
      d = $urandom;
      apb(1'b1, OFS_TRANSMIT_DATA, d);
      chk("transmit_data", {24'h0, txDataOut}, {24'h0, d[7:0]});
    end
  endtask
  task automatic drain_tx(int n);
    txDrainReq <= 1'b1;
    step(n);
    txDrainReq <= 1'b0;
    step(2);
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc > 5000) begin
      err_count++;
      close_out();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(56));
    step(2);
    rst_n <= 1'b1;
    apb(1'b0, OFS_RAW_EVENT_STATUS, 32'h0);
    chk("raw", rd, 32'h0);
    apb(1'b0, 13'h0010, 32'h0);
    chk("slverr", {31'h0, er}, 32'h1);
    apb(1'b1, OFS_POWER_ENABLE, 32'h0000_0001);
    apb(1'b0, OFS_POWER_ENABLE, 32'h0);
    chk("nokey", rd, 32'h0);
    apb(1'b1, OFS_POWER_ENABLE, 32'h2600_0001);
    apb(1'b0, OFS_POWER_ENABLE, 32'h0);
    chk("key", rd, 32'h1);
    apb(1'b1, OFS_EVENT_SET, EVENT_BITS);
    chk("setrx", receive_dma_request, 1'b1);
    chk("settx", transmit_dma_request, 1'b1);
    apb(1'b1, OFS_EVENT_CLEAR, EVENT_BITS);
    chk("clr", {receive_dma_request, transmit_dma_request}, 2'b00);
    apb(1'b1, OFS_SERIAL_CONTROL_ZERO, 32'h2);
    apb(1'b1, OFS_FIFO_LEVEL_SELECT, 32'h11);
    apb(1'b1, OFS_EVENT_MASK, EVENT_BITS);
    push_rx(7);
    step(1);
    chk("rxbelow", receive_dma_request, 1'b0);
    push_rx(1);
    step(1);
    chk("rxlevel", receive_dma_request, 1'b1);
    chk("txquiet", transmit_dma_request, 1'b0);
    rd_rx();
    step(2);
    chk("rxdrop", receive_dma_request, 1'b0);
    wr_tx(10);
    drain_tx(2);
    chk("txlevel", transmit_dma_request, 1'b1);
    apb(1'b0, OFS_PENDING_EVENT_INDEX, 32'h0);
    chk("index", rd, {24'h0, IDX_TX_LEVEL});
    chk("idxclr", transmit_dma_request, 1'b0);
    wr_tx(2);
    drain_tx(2);
    chk("txagain", transmit_dma_request, 1'b1);
    apb(1'b1, OFS_EVENT_CLEAR, 32'h800);
    chk("txclr", transmit_dma_request, 1'b0);
    repeat (7) rd_rx();
    apb(1'b1, OFS_FIFO_LEVEL_SELECT, 32'h111);
    push_rx(2);
    step(4);
    chk("toearly", receive_dma_request, 1'b0);
    step(20);
    chk("timeout", receive_dma_request, 1'b1);
    rd_rx();
    rd_rx();
    step(2);
    chk("toclr", receive_dma_request, 1'b0);
    apb(1'b1, OFS_DEBUG_BEHAVIOUR_CONTROL, 32'h1);
    cpuHalted <= 1'b1;
    step(3);
    chk("free", moduleRunEnable, 1'b1);
    cpuHalted <= 1'b0;
    apb(1'b1, OFS_DEBUG_BEHAVIOUR_CONTROL, 32'h2);
    transferBusy <= 1'b1;
    cpuHalted <= 1'b1;
    step(3);
    chk("softbusy", moduleRunEnable, 1'b1);
    transferBusy <= 1'b0;
    step(3);
    chk("softstop", moduleRunEnable, 1'b0);
    cpuHalted <= 1'b0;
    apb(1'b1, OFS_DEBUG_BEHAVIOUR_CONTROL, 32'h0);
    chk("resume", moduleRunEnable, 1'b1);
    transferBusy <= 1'b1;
    cpuHalted <= 1'b1;
    step(2);
    chk("hardstop", moduleRunEnable, 1'b0);
    cpuHalted <= 1'b0;
    transferBusy <= 1'b0;
    apb(1'b1, OFS_SERIAL_CONTROL_ZERO, 32'h0);
    push_rx(1);
    step(1);
    chk("rxone", receive_dma_request, 1'b1);
    rd_rx();
    step(2);
    chk("rxoneclr", receive_dma_request, 1'b0);
    drain_tx(8);
    chk("txempty", transmit_dma_request, 1'b1);
    wr_tx(1);
    chk("txwrite", transmit_dma_request, 1'b0);
    close_out();
  end
endmodule // udt_dma_trigger_tb_top
